// [rtl/lvtp_top.sv]
// lvtp_top: vertical frame timing, ac flip, frame interrupt and the whole
// panel power sequence, up and down, with a simple register port.
// assumes line_tick_in and the control inputs come from logic on clock_in.
`timescale 1ns/100ps
`default_nettype none
module lvtp_top
  import lvtp_pkg::*;
(
  // clock and reset
  input  wire logic              clock_in,
  input  wire logic              sys_rst_in,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr_in,
  input  wire logic [DATA_W-1:0] reg_wdata_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  output logic      [DATA_W-1:0] reg_rdata_out,
  // from the rest of the controller
  input  wire logic              line_tick_in,
  input  wire logic              display_on_in,
  input  wire logic              dual_scan_in,
  input  wire logic [LINE_W-1:0] vert_visible_count_in,
  // panel side
  output logic                   frame_marker_out,
  output logic                   ac_flip_out,
  output logic                   logic_supply_pin_out,
  output logic                   drive_supply_pin_out,
  output logic                   display_on_out,
  // interrupts
  output logic                   frame_irq_line_out,
  output logic                   irq_out
);

  // next line in a frame of tot+1 lines
  function automatic logic [LINE_W-1:0] next_line(input logic [LINE_W-1:0] cur,
                                                  input logic [LINE_W-1:0] tot);
    next_line = (cur == tot) ? '0 : cur + 11'h001;
  endfunction : next_line

  // register state
  logic [LINE_W-1:0] vert_total_count_q;
  logic [VSW_W-1:0]  vsync_pulse_width_q;
  logic [LINE_W-1:0] vsync_pulse_position_q;
  logic [ACI_W-1:0]  ac_flip_interval_q;
  logic              vsync_irq_point_select_q;
  logic              vsync_irq_enable_q;
  logic              vsync_irq_pending_q;
  logic [3:0]        power_on_gap_frames_q;
  logic [3:0]        power_off_gap_frames_q;
  logic              logic_supply_pin_enable_q;
  logic              drive_supply_pin_enable_q;
  logic              display_on_enable_q;
  logic [EV_W-1:0]   ev_stat_q;
  logic [EV_W-1:0]   ev_en_q;

  // timing state
  logic [LINE_W-1:0] line_q;
  logic              vs_q;
  logic [VSW_W-1:0]  vs_left_q;
  logic [ACI_W-1:0]  ac_cnt_q;
  logic              ac_q;

  lvtp_seq_if sq ();

  lvtp_seq u_seq (
    .clock_in   (clock_in),
    .sys_rst_in (sys_rst_in),
    .sq         (sq)
  );

  // decode
  logic wr_vtotal;
  logic wr_vsync;
  logic wr_acint;
  logic wr_intctl;
  logic wr_pwrmod;
  logic wr_evclr;
  logic wr_even;

  assign wr_vtotal = reg_wr_in && reg_addr_in == OFS_VTOTAL;
  assign wr_vsync  = reg_wr_in && reg_addr_in == OFS_VSYNC;
  assign wr_acint  = reg_wr_in && reg_addr_in == OFS_ACINT;
  assign wr_intctl = reg_wr_in && reg_addr_in == OFS_INTCTL;
  assign wr_pwrmod = reg_wr_in && reg_addr_in == OFS_PWRMOD;
  assign wr_evclr  = reg_wr_in && reg_addr_in == OFS_EVCLR;
  assign wr_even   = reg_wr_in && reg_addr_in == OFS_EVEN;

  // frame events
  logic [LINE_W-1:0] line_nxt;
  logic [LINE_W:0]   eff_pos_w;
  logic [LINE_W-1:0] eff_pos;
  logic [LINE_W-1:0] vs_start;
  logic              frame_tick;
  logic              vs_begin;
  logic              fetch_retrace;
  logic              vsync_event;

  assign line_nxt   = next_line(line_q, vert_total_count_q);
  // odd position in dual scan: (p+1)/2 lines into the half panel
  assign eff_pos_w  = dual_scan_in ? ({1'b0, vsync_pulse_position_q} + 12'h001) >> 1
                                   : {1'b0, vsync_pulse_position_q};
  assign eff_pos    = eff_pos_w[LINE_W-1:0];
  // position one below the start line, as a frame-start pulse uses total
  assign vs_start   = next_line(eff_pos, vert_total_count_q);
  assign frame_tick = line_tick_in && line_q == vert_total_count_q;
  assign vs_begin   = line_tick_in && line_nxt == vs_start;
  assign fetch_retrace = line_tick_in &&
                         {1'b0, line_nxt} == {1'b0, vert_visible_count_in} + 12'h001;
  assign vsync_event = vsync_irq_point_select_q ? vs_begin : fetch_retrace;

  // line counter
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      line_q <= '0;
    end else if (line_tick_in) begin
      line_q <= line_nxt;
    end
  end

  // vsync pulse: width field plus one lines
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      vs_q      <= 1'b0;
      vs_left_q <= '0;
    end else if (vs_begin) begin
      vs_q      <= 1'b1;
      vs_left_q <= vsync_pulse_width_q;
    end else if (line_tick_in && vs_q) begin
      if (vs_left_q == 4'h0) begin
        vs_q <= 1'b0;
      end else begin
        vs_left_q <= vs_left_q - 4'h1;
      end
    end
  end

  // ac flip: counts lines, free running across frames
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      ac_cnt_q <= '0;
      ac_q     <= 1'b0;
    end else if (line_tick_in) begin
      if (ac_cnt_q >= ac_flip_interval_q) begin
        ac_cnt_q <= '0;
        ac_q     <= ~ac_q;
      end else begin
        ac_cnt_q <= ac_cnt_q + 5'h01;
      end
    end
  end

  // timing registers
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      vert_total_count_q     <= RST_VTOTAL[LINE_W-1:0];
      vsync_pulse_width_q    <= RST_VSYNC[VSW_LSB +: VSW_W];
      vsync_pulse_position_q <= RST_VSYNC[LINE_W-1:0];
      ac_flip_interval_q     <= RST_ACINT[ACI_W-1:0];
    end else begin
      if (wr_vtotal) begin
        vert_total_count_q <= reg_wdata_in[LINE_W-1:0];
      end
      if (wr_vsync) begin
        vsync_pulse_width_q    <= reg_wdata_in[VSW_LSB +: VSW_W];
        vsync_pulse_position_q <= reg_wdata_in[LINE_W-1:0];
      end
      if (wr_acint) begin
        ac_flip_interval_q <= reg_wdata_in[ACI_W-1:0];
      end
    end
  end

  // interrupt control; a new event wins over a clearing write
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      vsync_irq_point_select_q <= RST_INTCTL[ISEL_BIT];
      vsync_irq_enable_q       <= RST_INTCTL[IEN_BIT];
      vsync_irq_pending_q      <= RST_INTCTL[IPND_BIT];
    end else begin
      if (wr_intctl) begin
        vsync_irq_point_select_q <= reg_wdata_in[ISEL_BIT];
        vsync_irq_enable_q       <= reg_wdata_in[IEN_BIT];
      end
      // writing one leaves the flag alone; only zero clears
      if (vsync_event) begin
        vsync_irq_pending_q <= 1'b1;
      end else if (wr_intctl && !reg_wdata_in[IPND_BIT]) begin
        vsync_irq_pending_q <= 1'b0;
      end
    end
  end

  // power mode register
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      power_on_gap_frames_q     <= RST_PWRMOD[ONG_LSB +: GAP_W];
      power_off_gap_frames_q    <= RST_PWRMOD[OFFG_LSB +: GAP_W];
      logic_supply_pin_enable_q <= RST_PWRMOD[LSPE_BIT];
      drive_supply_pin_enable_q <= RST_PWRMOD[DSPE_BIT];
      display_on_enable_q       <= RST_PWRMOD[DONE_BIT];
    end else if (wr_pwrmod) begin
      power_on_gap_frames_q     <= reg_wdata_in[ONG_LSB +: GAP_W];
      power_off_gap_frames_q    <= reg_wdata_in[OFFG_LSB +: GAP_W];
      logic_supply_pin_enable_q <= reg_wdata_in[LSPE_BIT];
      drive_supply_pin_enable_q <= reg_wdata_in[DSPE_BIT];
      display_on_enable_q       <= reg_wdata_in[DONE_BIT];
    end
  end

  // sequencer hookup
  assign sq.frame_tick = frame_tick;
  assign sq.power_req  = display_on_in;
  assign sq.on_gap     = power_on_gap_frames_q;
  assign sq.off_gap    = power_off_gap_frames_q;
  assign sq.pin_en     = {logic_supply_pin_enable_q, drive_supply_pin_enable_q,
                          display_on_enable_q};

  // event status: set wins over clear
  logic [EV_W-1:0] ev_set;

  assign ev_set = {sq.down_done, sq.up_done, vsync_event};

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      ev_stat_q <= '0;
      ev_en_q   <= '0;
    end else begin
      ev_stat_q <= ev_set | (ev_stat_q & ~(wr_evclr ? reg_wdata_in[EV_W-1:0] : 3'h0));
      if (wr_even) begin
        ev_en_q <= reg_wdata_in[EV_W-1:0];
      end
    end
  end

  // read data: valid only in the cycle after the strobe
  logic [DATA_W-1:0] rd_mux;

  always_comb begin
    rd_mux = '0;
    case (reg_addr_in)
      OFS_VTOTAL: rd_mux[LINE_W-1:0] = vert_total_count_q;
      OFS_VSYNC: begin
        rd_mux[VSW_LSB +: VSW_W] = vsync_pulse_width_q;
        rd_mux[LINE_W-1:0]       = vsync_pulse_position_q;
      end
      OFS_ACINT: rd_mux[ACI_W-1:0] = ac_flip_interval_q;
      OFS_INTCTL: begin
        rd_mux[ISEL_BIT] = vsync_irq_point_select_q;
        rd_mux[IEN_BIT]  = vsync_irq_enable_q;
        rd_mux[IPND_BIT] = vsync_irq_pending_q;
      end
      OFS_PWRMOD: begin
        rd_mux[ONG_LSB +: GAP_W]  = power_on_gap_frames_q;
        rd_mux[OFFG_LSB +: GAP_W] = power_off_gap_frames_q;
        rd_mux[LSPE_BIT]          = logic_supply_pin_enable_q;
        rd_mux[DSPE_BIT]          = drive_supply_pin_enable_q;
        rd_mux[DONE_BIT]          = display_on_enable_q;
        rd_mux[1:0]               = sq.state;
      end
      OFS_EVSTAT: rd_mux[EV_W-1:0] = ev_stat_q;
      OFS_EVEN:   rd_mux[EV_W-1:0] = ev_en_q;
      default:    rd_mux = '0;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= '0;
    end else begin
      reg_rdata_out <= reg_rd_in ? rd_mux : '0;
    end
  end

  // registered outputs, one cycle behind their sources
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      frame_marker_out     <= 1'b0;
      ac_flip_out          <= 1'b0;
      logic_supply_pin_out <= 1'b0;
      drive_supply_pin_out <= 1'b0;
      display_on_out       <= 1'b0;
      frame_irq_line_out   <= 1'b0;
      irq_out              <= 1'b0;
    end else begin
      frame_marker_out     <= vs_q;
      ac_flip_out          <= ac_q;
      logic_supply_pin_out <= sq.logic_pin;
      drive_supply_pin_out <= sq.drive_pin;
      display_on_out       <= sq.disp_pin;
      frame_irq_line_out   <= vsync_irq_pending_q & vsync_irq_enable_q;
      irq_out              <= |(ev_stat_q & ev_en_q);
    end
  end

endmodule : lvtp_top
`default_nettype wire

// [rtl/lvtp_pkg.sv]
// lvtp_pkg: register map, field layout, reset values and states of the
// vertical timing and panel power block.
// assumes a 16-bit register port with byte offsets on an 8-bit address.
package lvtp_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned LINE_W = 11;

  // register offsets
  localparam logic [7:0] OFS_VTOTAL = 8'h00;
  localparam logic [7:0] OFS_VSYNC  = 8'h04;
  localparam logic [7:0] OFS_ACINT  = 8'h08;
  localparam logic [7:0] OFS_INTCTL = 8'h0c;
  localparam logic [7:0] OFS_PWRMOD = 8'h10;
  localparam logic [7:0] OFS_EVSTAT = 8'h14;
  localparam logic [7:0] OFS_EVCLR  = 8'h18;
  localparam logic [7:0] OFS_EVEN   = 8'h1c;

  // field positions
  localparam int unsigned VSW_LSB   = 12;
  localparam int unsigned VSW_W     = 4;
  localparam int unsigned ACI_W     = 5;
  localparam int unsigned ISEL_BIT  = 12;
  localparam int unsigned IEN_BIT   = 8;
  localparam int unsigned IPND_BIT  = 0;
  localparam int unsigned ONG_LSB   = 12;
  localparam int unsigned OFFG_LSB  = 8;
  localparam int unsigned GAP_W     = 4;
  localparam int unsigned LSPE_BIT  = 6;
  localparam int unsigned DSPE_BIT  = 5;
  localparam int unsigned DONE_BIT  = 4;
  localparam int unsigned EV_W      = 3;
  localparam int unsigned EV_VSYNC  = 0;
  localparam int unsigned EV_PWRUP  = 1;
  localparam int unsigned EV_PWRDN  = 2;

  // reset values
  localparam logic [15:0] RST_VTOTAL = 16'h01df;
  localparam logic [15:0] RST_VSYNC  = 16'h01df;
  localparam logic [15:0] RST_ACINT  = 16'h000c;
  localparam logic [15:0] RST_INTCTL = 16'h0000;
  localparam logic [15:0] RST_PWRMOD = 16'h0010;

  typedef enum logic [1:0] {
    LVTP_PWR_OFF,
    LVTP_PWR_UP,
    LVTP_PWR_ON,
    LVTP_PWR_DOWN
  } lvtp_pwr_e;

endpackage : lvtp_pkg

// [rtl/lvtp_seq_if.sv]
// lvtp_seq_if: signals between the timing core and the power sequencer.
// assumes both ends run on clock_in.
`timescale 1ns/100ps
`default_nettype none
interface lvtp_seq_if;
  logic       frame_tick;
  logic       power_req;
  logic [3:0] on_gap;
  logic [3:0] off_gap;
  logic [2:0] pin_en;
  logic       logic_pin;
  logic       drive_pin;
  logic       disp_pin;
  logic [1:0] state;
  logic       up_done;
  logic       down_done;

  modport seq (input frame_tick, power_req, on_gap, off_gap, pin_en,
               output logic_pin, drive_pin, disp_pin, state, up_done, down_done);
  modport ctl (output frame_tick, power_req, on_gap, off_gap, pin_en,
               input logic_pin, drive_pin, disp_pin, state, up_done, down_done);
endinterface : lvtp_seq_if
`default_nettype wire

// [rtl/lvtp_seq.sv]
// lvtp_seq: panel power sequencer counting frame starts between pin steps.
// assumes frame_tick is a one-cycle pulse at each frame start.
`timescale 1ns/100ps
`default_nettype none
module lvtp_seq
  import lvtp_pkg::*;
(
  // clock and reset
  input  wire logic clock_in,
  input  wire logic sys_rst_in,
  // sequencer link
  lvtp_seq_if.seq   sq
);

  lvtp_pwr_e  st_q;
  logic [3:0] gap_q;
  logic       sup_q;
  logic       don_q;
  logic       upd_q;
  logic       dnd_q;

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      st_q  <= LVTP_PWR_OFF;
      gap_q <= 4'h0;
      sup_q <= 1'b0;
      don_q <= 1'b0;
      upd_q <= 1'b0;
      dnd_q <= 1'b0;
    end else begin
      upd_q <= 1'b0;
      dnd_q <= 1'b0;
      case (st_q)
        LVTP_PWR_OFF: begin
          if (sq.power_req) begin
            sup_q <= 1'b1;
            gap_q <= sq.on_gap;
            st_q  <= LVTP_PWR_UP;
          end
        end
        // field is frame starts minus one, so a zero field still waits for the next frame start
        LVTP_PWR_UP: begin
          if (sq.frame_tick) begin
            if (gap_q == 4'h0) begin
              don_q <= 1'b1;
              upd_q <= 1'b1;
              st_q  <= LVTP_PWR_ON;
            end else begin
              gap_q <= gap_q - 4'h1;
            end
          end
        end
        LVTP_PWR_ON: begin
          if (!sq.power_req) begin
            don_q <= 1'b0;
            gap_q <= sq.off_gap;
            st_q  <= LVTP_PWR_DOWN;
          end
        end
        LVTP_PWR_DOWN: begin
          if (sq.frame_tick) begin
            if (gap_q == 4'h0) begin
              sup_q <= 1'b0;
              dnd_q <= 1'b1;
              st_q  <= LVTP_PWR_OFF;
            end else begin
              gap_q <= gap_q - 4'h1;
            end
          end
        end
        default: st_q <= LVTP_PWR_OFF;
      endcase
    end
  end

  // pins masked low by their enables
  assign sq.logic_pin = sup_q & sq.pin_en[2];
  assign sq.drive_pin = sup_q & sq.pin_en[1];
  assign sq.disp_pin  = don_q & sq.pin_en[0];
  assign sq.state     = (st_q == LVTP_PWR_ON || st_q == LVTP_PWR_DOWN) ? 2'b11 : 2'b00;
  assign sq.up_done   = upd_q;
  assign sq.down_done = dnd_q;

endmodule : lvtp_seq
`default_nettype wire

// [verif/lvtp_top_properties.sv]
// lvtp_top_properties: port-level checks of lvtp_top, bound to each instance.
// assumes the register port is the only way the control fields change.
`timescale 1ns/100ps
`default_nettype none
module lvtp_top_properties
  import lvtp_pkg::*;
(
  // clock and reset
  input wire logic              clock_in,
  input wire logic              sys_rst_in,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  input wire logic              reg_wr_in,
  input wire logic              reg_rd_in,
  input wire logic [DATA_W-1:0] reg_rdata_out,
  // controller side
  input wire logic              line_tick_in,
  input wire logic              display_on_in,
  input wire logic              dual_scan_in,
  input wire logic [LINE_W-1:0] vert_visible_count_in,
  // panel and interrupts
  input wire logic              frame_marker_out,
  input wire logic              ac_flip_out,
  input wire logic              logic_supply_pin_out,
  input wire logic              drive_supply_pin_out,
  input wire logic              display_on_out,
  input wire logic              frame_irq_line_out,
  input wire logic              irq_out
);
  // shadows of written fields; the total line readback and the pin and interrupt gating checks use these
  logic [10:0] vt_q;
  logic [2:0]  pen_q;
  logic        ien_q;
  logic [2:0]  een_q;

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      vt_q  <= RST_VTOTAL[10:0];
      pen_q <= RST_PWRMOD[6:4];
      ien_q <= 1'b0;
      een_q <= 3'h0;
    end else if (reg_wr_in) begin
      if (reg_addr_in == OFS_VTOTAL) vt_q <= reg_wdata_in[10:0];
      if (reg_addr_in == OFS_PWRMOD) pen_q <= reg_wdata_in[6:4];
      if (reg_addr_in == OFS_INTCTL) ien_q <= reg_wdata_in[IEN_BIT];
      if (reg_addr_in == OFS_EVEN) een_q <= reg_wdata_in[2:0];
    end
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);

  a_vtotal_readback: assert property (
    $past(reg_rd_in && reg_addr_in == OFS_VTOTAL) |-> reg_rdata_out == {5'h00, $past(vt_q)})
    else $error("total line field read back wrong");
  a_state_pairs: assert property (
    $past(reg_rd_in && reg_addr_in == OFS_PWRMOD)
    |-> (reg_rdata_out[1:0] == 2'b00) || (reg_rdata_out[1:0] == 2'b11))
    else $error("power state reads a mixed pair");
  a_logic_pin_masked: assert property (
    !pen_q[2] && !$past(pen_q[2]) && !$past(pen_q[2], 2) |-> !logic_supply_pin_out)
    else $error("logic supply pin high while disabled");
  a_drive_pin_masked: assert property (
    !pen_q[1] && !$past(pen_q[1]) && !$past(pen_q[1], 2) |-> !drive_supply_pin_out)
    else $error("drive supply pin high while disabled");
  a_disp_pin_masked: assert property (
    !pen_q[0] && !$past(pen_q[0]) && !$past(pen_q[0], 2) |-> !display_on_out)
    else $error("display pin high while disabled");
  a_frame_irq_gated: assert property (
    $rose(frame_irq_line_out) |-> ien_q || $past(ien_q))
    else $error("frame interrupt rose while disabled");
  a_event_irq_gated: assert property (
    $rose(irq_out) |-> (een_q != 3'h0) || ($past(een_q) != 3'h0))
    else $error("event interrupt rose with no enable");
  a_marker_rise_tick: assert property (
    $rose(frame_marker_out) |-> $past(line_tick_in, 2))
    else $error("sync pulse began off a line boundary");
  a_marker_fall_tick: assert property (
    $fell(frame_marker_out) |-> $past(line_tick_in, 2))
    else $error("sync pulse ended off a line boundary");
  a_ac_on_tick: assert property (
    $changed(ac_flip_out) |-> $past(line_tick_in) || $past(line_tick_in, 2))
    else $error("ac output flipped off a line boundary");
endmodule : lvtp_top_properties

bind lvtp_top lvtp_top_properties lvtp_top_properties_inst (
  .clock_in(clock_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .line_tick_in(line_tick_in),
  .display_on_in(display_on_in), .dual_scan_in(dual_scan_in),
  .vert_visible_count_in(vert_visible_count_in), .frame_marker_out(frame_marker_out),
  .ac_flip_out(ac_flip_out), .logic_supply_pin_out(logic_supply_pin_out),
  .drive_supply_pin_out(drive_supply_pin_out), .display_on_out(display_on_out),
  .frame_irq_line_out(frame_irq_line_out), .irq_out(irq_out));
`default_nettype wire

// [verif/lvtp_panel_model.sv]
// lvtp_panel_model: panel supply switch, timing the gaps between its pins.
// assumes pins are sampled on the controller clock; gaps count in cycles.
`timescale 1ns/100ps
`default_nettype none
module lvtp_panel_model (
  // clock
  input  wire logic        clock_in,
  // panel pins
  input  wire logic        drive_supply_pin_in,
  input  wire logic        display_on_pin_in,
  // measured gaps
  output logic      [15:0] up_gap_out,
  output logic      [15:0] down_gap_out
);
  logic [15:0] cnt_q;
  logic        drv_q;
  logic        don_q;

  // one counter serves both gaps, as the sequences never overlap
  always_ff @(posedge clock_in) begin
    drv_q <= drive_supply_pin_in;
    don_q <= display_on_pin_in;
    if ((drive_supply_pin_in && !drv_q) || (!display_on_pin_in && don_q)) cnt_q <= 16'h0001;
    else cnt_q <= cnt_q + 16'h0001;
    if (display_on_pin_in && !don_q) up_gap_out <= cnt_q;
    if (!drive_supply_pin_in && drv_q) down_gap_out <= cnt_q;
  end
endmodule : lvtp_panel_model
`default_nettype wire

// [verif/lvtp_top_tb.sv]
// lvtp_top_tb: directed scenarios for lvtp_top with a panel model.
// assumes one line every four clocks and an eight-line frame once set up.
`timescale 1ns/100ps
`default_nettype none
module lvtp_top_tb
  import lvtp_pkg::*;
;
  logic        clock_in;
  logic        sys_rst_in;
  logic [7:0]  reg_addr_in;
  logic [15:0] reg_wdata_in;
  logic        reg_wr_in;
  logic        reg_rd_in;
  logic [15:0] reg_rdata_out;
  logic        line_tick_in = 1'b0;
  logic [1:0]  tick_cnt = 2'h0;
  logic        tick_en = 1'b0;
  logic        display_on_in;
  logic        dual_scan_in;
  logic [10:0] vert_visible_count_in;
  logic        frame_marker_out, ac_flip_out, logic_supply_pin_out;
  logic        drive_supply_pin_out, display_on_out, frame_irq_line_out, irq_out;
  logic [15:0] up_gap, down_gap;
  int          bad_count = 0;
  int          checks = 0;

  lvtp_top lvtp_top_inst (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .line_tick_in(line_tick_in),
    .display_on_in(display_on_in), .dual_scan_in(dual_scan_in),
    .vert_visible_count_in(vert_visible_count_in), .frame_marker_out(frame_marker_out),
    .ac_flip_out(ac_flip_out), .logic_supply_pin_out(logic_supply_pin_out),
    .drive_supply_pin_out(drive_supply_pin_out), .display_on_out(display_on_out),
    .frame_irq_line_out(frame_irq_line_out), .irq_out(irq_out));
  lvtp_panel_model lvtp_panel_model_inst (.clock_in(clock_in),
    .drive_supply_pin_in(drive_supply_pin_out), .display_on_pin_in(display_on_out),
    .up_gap_out(up_gap), .down_gap_out(down_gap));

  always #5 clock_in = ~clock_in;
  always @(posedge clock_in) begin
    tick_cnt <= tick_cnt + 2'h1;
    // no lines until t_fields has probed the registers, so no event races those readbacks
    line_tick_in <= (tick_cnt == 2'h3) && tick_en;
  end

  task automatic results;
    $display("checks %0d errors %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clock_in);
    reg_wr_in <= 1'b0;
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clock_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clock_in);
    reg_rd_in <= 1'b0;
    #1;
    chk(reg_rdata_out, exp);
  endtask : rdchk

  // counts edges until the chosen output shows lvl
  task automatic wait_sig(input int sel, input logic lvl, output int n);
    logic s;
    n = 0;
    do begin
      @(posedge clock_in);
      #1;
      n++;
      case (sel)
        0: s = frame_marker_out;
        1: s = frame_irq_line_out;
        2: s = irq_out;
        3: s = ac_flip_out;
        4: s = display_on_out;
        default: s = drive_supply_pin_out;
      endcase
    end while (s !== lvl && n < 400);
    if (n >= 400) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, s, lvl);
      results();
    end
  endtask : wait_sig

  task automatic t_fields;
    logic [7:0]  a [6] = '{OFS_INTCTL, OFS_VTOTAL, OFS_VSYNC, OFS_ACINT, OFS_PWRMOD, OFS_EVEN};
    logic [15:0] e [6] = '{16'h1100, 16'h07ff, 16'hf7ff, 16'h001f, 16'hff70, 16'h0007};
    rdchk(OFS_VTOTAL, 16'h01df);
    rdchk(OFS_VSYNC, 16'h01df);
    rdchk(OFS_ACINT, 16'h000c);
    rdchk(OFS_INTCTL, 16'h0000);
    rdchk(OFS_PWRMOD, 16'h0010);
    rdchk(8'h20, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      wr(a[i], 16'hffff);
      rdchk(a[i], e[i]);
    end
    wr(OFS_INTCTL, 16'h0000);
    wr(OFS_EVEN, 16'h0000);
    wr(OFS_PWRMOD, 16'h0010);
    wr(OFS_VTOTAL, 16'h0007);
    wr(OFS_VSYNC, 16'h2006);
    wr(OFS_ACINT, 16'h0002);
    wr(OFS_EVCLR, 16'h0007);
    tick_en <= 1'b1;
  endtask : t_fields

  task automatic t_shape;
    int n;
    wait_sig(0, 1'b1, n);
    wait_sig(0, 1'b0, n);
    chk(n[15:0], 16'h000c);
    wait_sig(0, 1'b1, n);
    chk(n[15:0], 16'h0014);
    wait_sig(3, ~ac_flip_out, n);
    wait_sig(3, ~ac_flip_out, n);
    chk(n[15:0], 16'h000c);
  endtask : t_shape

  task automatic irq_gap(input logic [15:0] ctl, output int n);
    int m;
    wr(OFS_INTCTL, ctl);
    wait_sig(1, 1'b1, m);
    wait_sig(0, 1'b1, n);
  endtask : irq_gap

  task automatic t_position;
    int n_fetch, n_panel, n_dual;
    irq_gap(16'h0100, n_fetch);
    irq_gap(16'h1100, n_panel);
    // fetch point is line 2, sync start line 7: five lines of four clocks
    chk(n_fetch[15:0], 16'h0014);
    // panel point and sync start share an edge; the wait counts one edge
    chk(n_panel[15:0], 16'h0001);
    @(posedge clock_in);
    dual_scan_in <= 1'b1;
    wr(OFS_VSYNC, 16'h200b);
    irq_gap(16'h0100, n_dual);
    chk(n_dual[15:0], 16'h0014);
    @(posedge clock_in);
    dual_scan_in <= 1'b0;
    wr(OFS_VSYNC, 16'h2006);
  endtask : t_position

  task automatic t_irq;
    int n;
    wait_sig(1, 1'b1, n);
    rdchk(OFS_INTCTL, 16'h0101);
    wr(OFS_INTCTL, 16'h0100);
    @(posedge clock_in);
    #1;
    chk({15'h0000, frame_irq_line_out}, 16'h0000);
    rdchk(OFS_INTCTL, 16'h0100);
    wr(OFS_EVEN, 16'h0001);
    wait_sig(2, 1'b1, n);
    rdchk(OFS_EVSTAT, 16'h0001);
    wr(OFS_EVCLR, 16'h0001);
    @(posedge clock_in);
    #1;
    chk({15'h0000, irq_out}, 16'h0000);
    wr(OFS_EVEN, 16'h0000);
  endtask : t_irq

  task automatic t_power;
    int n;
    wr(OFS_PWRMOD, 16'h1070);
    display_on_in <= 1'b1;
    wait_sig(4, 1'b1, n);
    chk({15'h0000, logic_supply_pin_out & drive_supply_pin_out}, 16'h0001);
    rdchk(OFS_PWRMOD, 16'h1073);
    // gaps land in the model one edge after the pin is seen; frame phase is free
    chk({15'h0000, up_gap >= 16'h0021 && up_gap <= 16'h0040}, 16'h0001);
    @(posedge clock_in);
    display_on_in <= 1'b0;
    wait_sig(5, 1'b0, n);
    rdchk(OFS_PWRMOD, 16'h1070);
    chk({15'h0000, down_gap >= 16'h0001 && down_gap <= 16'h0020}, 16'h0001);
    rdchk(OFS_EVSTAT, 16'h0007);
    wr(OFS_PWRMOD, 16'h1000);
    display_on_in <= 1'b1;
    repeat (100) @(posedge clock_in);
    #1;
    chk({13'h0000, logic_supply_pin_out, drive_supply_pin_out, display_on_out},
        16'h0000);
    rdchk(OFS_PWRMOD, 16'h1003);
  endtask : t_power

  initial begin
    clock_in = 1'b0;
    sys_rst_in = 1'b1;
    reg_addr_in = 8'h00;
    reg_wdata_in = 16'h0000;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    display_on_in = 1'b0;
    dual_scan_in = 1'b0;
    vert_visible_count_in = 11'h001;
    repeat (6) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    t_fields();
    t_shape();
    t_position();
    t_irq();
    t_power();
    results();
  end
endmodule : lvtp_top_tb
`default_nettype wire
